// ---- pkg/supervisor_params.svh ----
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH
`define CLK_FREQ_HZ 100000000
// times in their own units, as printed
`define HOLD_TIME_MS 250
`define WD_SHORT_MS 150
`define WD_MID_MS 600
`define WD_LONG_MS 1200
`define DEBOUNCE_TIME_MS 4
`define SUPPLY_ASSERT_MAX_US 150
`define KICK_PULSE_MIN_NS 20
// cycles derived from the rate
`define MS_TO_CYC(ms) ((ms) * (`CLK_FREQ_HZ / 1000))
`define HOLD_CYC `MS_TO_CYC(`HOLD_TIME_MS)
`define WD_SHORT_CYC `MS_TO_CYC(`WD_SHORT_MS)
`define WD_MID_CYC `MS_TO_CYC(`WD_MID_MS)
`define WD_LONG_CYC `MS_TO_CYC(`WD_LONG_MS)
`define DEBOUNCE_CYC `MS_TO_CYC(`DEBOUNCE_TIME_MS)
`define CNT_W 32
`endif

// ---- pkg/supervisor_pkg.sv ----
package supervisor_pkg;
  typedef enum logic [1:0] {
    wd_sel_short = 2'h0,
    wd_sel_mid = 2'h1,
    wd_sel_long = 2'h2
  } wd_sel_t;
  typedef enum logic [2:0] {
    st_run = 3'h1,
    st_active = 3'h2,
    st_hold = 3'h4
  } sup_state_t;
endpackage

// ---- pkg/debounce_if.sv ----
`timescale 1ns/1ns
interface debounce_if;
  logic raw_n;
  logic pressed;
  modport ctl (output raw_n, input pressed);
  modport filt (input raw_n, output pressed);
endinterface

// ---- verilog/manual_debounce.sv ----
`timescale 1ns/1ns
`include "supervisor_params.svh"
module manual_debounce #(
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  debounce_if.filt dbif
);
  logic [`CNT_W-1:0] stable_cnt;
  logic level_n;
  // a level must stand unbroken for the full count before it is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stable_cnt <= '0;
      level_n <= 1'b1;
      dbif.pressed <= 1'b0;
    end else begin
      level_n <= dbif.raw_n;
      if (dbif.raw_n != level_n) begin
        stable_cnt <= '0;
      end else if (stable_cnt >= DEBOUNCE_CYCLES[`CNT_W-1:0] - 32'h0000_0001) begin
        dbif.pressed <= !level_n;
      end else begin
        stable_cnt <= stable_cnt + 32'h0000_0001;
      end
    end
  end
endmodule // manual_debounce

// ---- verilog/supply_watchdog_reset_supervisor.sv ----
// Notes on behaviour
// - both resets active while the supply-low indication stands
// - threshold select low picks 5 percent trip, high picks 10 percent
// - resets held 250 ms after supply recovers
// - timeout select: low 150 ms, open 600 ms, high 1200 ms
// - missed kick within timeout asserts resets for the hold period
// - any kick falling edge restarts the watchdog count
// - manual reset debounced; recognised low forces resets active
// - lows under 1 ms ignored; lows of 20 ms always taken
// - supply low asserts both outputs well within 150 us
// - after manual reset release, resets held one hold period
`timescale 1ns/1ns
`include "supervisor_params.svh"
module supply_watchdog_reset_supervisor #(
  parameter int unsigned HOLD_CYCLES = `HOLD_CYC,
  parameter int unsigned WD_SHORT_CYCLES = `WD_SHORT_CYC,
  parameter int unsigned WD_MID_CYCLES = `WD_MID_CYC,
  parameter int unsigned WD_LONG_CYCLES = `WD_LONG_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_below_5pct,
  input wire logic supply_below_10pct,
  input wire logic threshold_select,
  input wire logic [1:0] timeout_select,
  input wire logic watchdog_kick_n,
  input wire logic manual_reset_n,
  output logic reset_out,
  output logic reset_out_n,
  output logic reset_out_n_oe
);
  supervisor_pkg::sup_state_t state;
  supervisor_pkg::wd_sel_t wd_sel;
  logic [1:0] supply_a, supply_b, kick_s, mr_s, tol_s;
  logic [1:0] tsel_a, tsel_b;
  logic kick_last;
  logic [`CNT_W-1:0] hold_cnt;
  logic [`CNT_W-1:0] wd_cnt;
  logic supply_low, kick_fall, wd_expired, cause;
  debounce_if dbif ();

  // every pin except rst_n passes two flops before any logic looks at it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_a <= 2'h0;
      supply_b <= 2'h0;
      kick_s <= 2'h3;
      mr_s <= 2'h3;
      tol_s <= 2'h0;
      tsel_a <= 2'h0;
      tsel_b <= 2'h0;
    end else begin
      supply_a <= {supply_below_10pct, supply_below_5pct};
      supply_b <= supply_a;
      kick_s <= {kick_s[0], watchdog_kick_n};
      mr_s <= {mr_s[0], manual_reset_n};
      tol_s <= {tol_s[0], threshold_select};
      tsel_a <= timeout_select;
      tsel_b <= tsel_a;
    end
  end

  assign dbif.raw_n = mr_s[1];

  manual_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_debounce (
    .clk(clk),
    .rst_n(rst_n),
    .dbif(dbif)
  );

  function automatic logic [`CNT_W-1:0] wd_limit(input supervisor_pkg::wd_sel_t s);
    unique case (s)
      supervisor_pkg::wd_sel_short: wd_limit = WD_SHORT_CYCLES[`CNT_W-1:0];
      supervisor_pkg::wd_sel_long: wd_limit = WD_LONG_CYCLES[`CNT_W-1:0];
      default: wd_limit = WD_MID_CYCLES[`CNT_W-1:0];
    endcase
  endfunction

  // 10 percent trip is the lower voltage, so it uses the second comparator
  assign supply_low = tol_s[1] ? supply_b[1] : supply_b[0];
  assign kick_fall = kick_last && !kick_s[1];
  assign wd_expired = wd_cnt >= wd_limit(wd_sel) - 32'h0000_0001;
  assign cause = supply_low || dbif.pressed;

  // timeout select 0 = low, 1 = open, 2 or 3 = high; the strap is re-read at each release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wd_sel <= supervisor_pkg::wd_sel_mid;
    end else if (state != supervisor_pkg::st_run) begin
      unique case (tsel_b)
        2'h0: wd_sel <= supervisor_pkg::wd_sel_short;
        2'h1: wd_sel <= supervisor_pkg::wd_sel_mid;
        default: wd_sel <= supervisor_pkg::wd_sel_long;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kick_last <= 1'b1;
    end else begin
      kick_last <= kick_s[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wd_cnt <= '0;
    end else if (state != supervisor_pkg::st_run || kick_fall) begin
      wd_cnt <= '0;
    end else begin
      wd_cnt <= wd_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= supervisor_pkg::st_active;
      hold_cnt <= '0;
    end else begin
      unique case (state)
        supervisor_pkg::st_run: begin
          if (cause) begin
            state <= supervisor_pkg::st_active;
          end else if (wd_expired) begin
            state <= supervisor_pkg::st_hold;
            hold_cnt <= '0;
          end
        end
        supervisor_pkg::st_active: begin
          hold_cnt <= '0;
          if (!cause) begin
            state <= supervisor_pkg::st_hold;
          end
        end
        supervisor_pkg::st_hold: begin
          if (cause) begin
            state <= supervisor_pkg::st_active;
          end else if (hold_cnt >= HOLD_CYCLES[`CNT_W-1:0] - 32'h0000_0001) begin
            state <= supervisor_pkg::st_run;
          end else begin
            hold_cnt <= hold_cnt + 32'h0000_0001;
          end
        end
        default: state <= supervisor_pkg::st_active;
      endcase
    end
  end

  // outputs registered; open drain low output drives only while asserted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_out <= 1'b1;
      reset_out_n <= 1'b0;
      reset_out_n_oe <= 1'b1;
    end else begin
      reset_out <= (state != supervisor_pkg::st_run);
      reset_out_n <= 1'b0;
      reset_out_n_oe <= (state != supervisor_pkg::st_run);
    end
  end
endmodule // supply_watchdog_reset_supervisor

// ---- bench/supervisor_sva.sv ----
`timescale 1ns/1ns
module supervisor_sva #(
  parameter int unsigned HOLD_CYCLES = 50,
  parameter int unsigned WD_SHORT_CYCLES = 40,
  parameter int unsigned WD_LONG_CYCLES = 120,
  parameter int unsigned DEBOUNCE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_below_5pct,
  input wire logic supply_below_10pct,
  input wire logic threshold_select,
  input wire logic watchdog_kick_n,
  input wire logic manual_reset_n,
  input wire logic reset_out,
  input wire logic reset_out_n,
  input wire logic reset_out_n_oe
);
  int hi, ml, idle;
  wire sup_low = threshold_select ? supply_below_10pct : supply_below_5pct;
  wire calm = !reset_out && idle < WD_SHORT_CYCLES - 10 && manual_reset_n && !sup_low;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // idle runs ahead of the design's count, which sees kicks two edges late
  always_ff @(posedge clk) begin
    // cleared in reset so an unknown output before the first edge cannot stick in the count
    hi <= (!rst_n || !reset_out) ? 0 : hi + 1;
    ml <= manual_reset_n ? 0 : ml + 1;
    idle <= (reset_out || $fell(watchdog_kick_n)) ? 0 : idle + 1;
  end
  property p_cmpl; reset_out == reset_out_n_oe; endproperty
  a_cmpl: assert property (p_cmpl) else $error("outputs disagree");
  property p_drv; reset_out_n == 1'b0; endproperty
  a_drv: assert property (p_drv) else $error("drain data high");
  property p_sup; sup_low [*5] |-> reset_out; endproperty
  a_sup: assert property (p_sup) else $error("supply low missed");
  property p_hold; $fell(reset_out) |-> hi >= HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
  property p_mr; ml > DEBOUNCE_CYCLES + 6 |-> reset_out; endproperty
  a_mr: assert property (p_mr) else $error("manual low missed");
  property p_wd; idle <= WD_LONG_CYCLES + 6; endproperty
  a_wd: assert property (p_wd) else $error("watchdog missed");
  property p_mrh; $rose(manual_reset_n) && reset_out |=> reset_out [*8]; endproperty
  a_mrh: assert property (p_mrh) else $error("early release");
  property p_quiet; calm [*5] |=> !reset_out; endproperty
  a_quiet: assert property (p_quiet) else $error("reset without cause");
  c_sup: cover property (sup_low ##5 reset_out);
  c_rel: cover property ($fell(reset_out));
  c_mr: cover property (ml == DEBOUNCE_CYCLES + 6);
endmodule // supervisor_sva
bind supply_watchdog_reset_supervisor supervisor_sva #(.HOLD_CYCLES(HOLD_CYCLES),
  .WD_SHORT_CYCLES(WD_SHORT_CYCLES), .WD_LONG_CYCLES(WD_LONG_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk (.*);

// ---- bench/host_model.sv ----
`timescale 1ns/1ns
module host_model (
  input wire logic clk,
  input wire logic kick_en,
  input wire logic reset_out_n,
  input wire logic reset_out_n_oe,
  output logic watchdog_kick_n
);
  int cnt = 0;
  // pulled-up line: low only while driven; a host held in reset stops kicking
  wire line_n = reset_out_n_oe ? reset_out_n : 1'b1;
  initial watchdog_kick_n = 1'b1;
  always @(negedge clk) begin
    cnt = (!kick_en || !line_n) ? 0 : (cnt + 1) % 20;
    watchdog_kick_n <= cnt >= 2;
  end
endmodule // host_model

// ---- bench/test_supply_watchdog_reset_supervisor.sv ----
`timescale 1ns/1ns
module test_supply_watchdog_reset_supervisor;
  logic clk = 0, rst_n = 0, supply_below_5pct = 0, supply_below_10pct = 0;
  logic threshold_select = 0, manual_reset_n = 1, kick_en = 1;
  logic [1:0] timeout_select = 2'h0;
  logic watchdog_kick_n, reset_out, reset_out_n, reset_out_n_oe;
  logic [31:0] lfsr = 32'h0000_8eaa;
  int num_errors = 0, total_checks = 0, cyc = 0, n;
  always #5 clk = ~clk;
  supply_watchdog_reset_supervisor #(.HOLD_CYCLES(50), .WD_SHORT_CYCLES(40),
    .WD_MID_CYCLES(80), .WD_LONG_CYCLES(120), .DEBOUNCE_CYCLES(8)) uut (.*);
  host_model host (.*);
  function automatic logic [31:0] step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int wd_lim(int s);
    return s == 0 ? 40 : s == 1 ? 80 : 120;
  endfunction
  task automatic chk(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(int k);
    repeat (k) @(negedge clk);
  endtask
  // counts cycles until reset_out reaches v, bounded
  task automatic until_out(logic v);
    n = 0;
    while (reset_out !== v && n < 400) begin
      run(1);
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (++cyc == 6000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    run(6);
    rst_n = 1;
    until_out(1'b0);
    chk(n inside {[48:56]}, 1'b1);
    run(300);
    chk(reset_out, 1'b0);
    $display("test reset and kicking done");
    for (int s = 0; s < 3; s++) begin
      timeout_select = s[1:0];
      kick_en = 0;
      manual_reset_n = 0;
      run(60);
      chk(reset_out, 1'b1);
      manual_reset_n = 1;
      until_out(1'b0);
      // release waits for the debounce of the high level, then the full hold
      chk(n inside {[58:66]}, 1'b1);
      until_out(1'b1);
      chk(n inside {[wd_lim(s) - 2:wd_lim(s) + 6]}, 1'b1);
      kick_en = 1;
      until_out(1'b0);
      chk(n inside {[48:56]}, 1'b1);
    end
    $display("test watchdog done");
    for (int t = 0; t < 2; t++) begin
      threshold_select = t[0];
      {supply_below_5pct, supply_below_10pct} = t ? 2'b10 : 2'b01;
      run(20);
      chk(reset_out, 1'b0);
      {supply_below_5pct, supply_below_10pct} = 2'b11;
      run(6);
      chk(reset_out, 1'b1);
      lfsr = step(lfsr);
      run(10 + lfsr[5:0]);
      chk(reset_out, 1'b1);
      {supply_below_5pct, supply_below_10pct} = 2'b00;
      until_out(1'b0);
      chk(n inside {[48:56]}, 1'b1);
    end
    $display("test supply done");
    repeat (6) begin
      lfsr = step(lfsr);
      manual_reset_n = 0;
      run(1 + lfsr[2:0] % 6);
      manual_reset_n = 1;
      run(20);
      chk(reset_out, 1'b0);
    end
    $display("test short manual pulses done");
    final_report();
  end
endmodule // test_supply_watchdog_reset_supervisor
